// *** common/adccfg_map.vh ***
// Purpose: constants for the adc configuration register bank
// Assumes: byte-wide registers reached over a three-wire serial link
// Notes: offsets are register numbers on the serial link
//
// Function
// - load defaults after 2^20 post-power-on cycles
// - reset pin restores every register default
// - address space 0x000 to 0x15D, sparse
// - eight volatile bits per register
// - all writable except last four, read-only
// - registers selected only by serial address
// - mirrored power and bit-order control byte
// - divider independence bit plus factory bits
// - output word and strobe rate fields
// - readback edge select plus factory bits
// - pll output and bias enables
// - format, output mode, pattern generator select
// - decimated strobe phase delay controls
// - six lane polarity bits, two unused
// - low byte of offset correction value
// - sixteen-bit header then data bytes
// - address increments per byte, holds at 0x15D, wraps past 0x3FF
`ifndef ADCCFG_MAP_VH
`define ADCCFG_MAP_VH

// ----------------------------------------
// register numbers
// ----------------------------------------
`define ADCCFG_A_PWR 10'h000
`define ADCCFG_A_DIVIND 10'h001
`define ADCCFG_A_RATE 10'h002
`define ADCCFG_A_RDTIME 10'h004
`define ADCCFG_A_RAND 10'h007
`define ADCCFG_A_CALDLY 10'h01E
`define ADCCFG_A_DLL 10'h052
`define ADCCFG_A_CLKSRC 10'h053
`define ADCCFG_A_PLLREF 10'h054
`define ADCCFG_A_PLLOUT 10'h055
`define ADCCFG_A_PRELO 10'h056
`define ADCCFG_A_PREHI 10'h057
`define ADCCFG_A_CPUMP 10'h058
`define ADCCFG_A_PLLEN1 10'h059
`define ADCCFG_A_LRES 10'h05A
`define ADCCFG_A_LCAP3 10'h05B
`define ADCCFG_A_LCAP1 10'h05C
`define ADCCFG_A_LCAP2 10'h05D
`define ADCCFG_A_PLLEN2 10'h05F
`define ADCCFG_A_FMT 10'h062
`define ADCCFG_A_DRIVE 10'h063
`define ADCCFG_A_PHASE 10'h064
`define ADCCFG_A_POL 10'h065
`define ADCCFG_A_OFSLO 10'h066
`define ADCCFG_A_LAST 10'h15D
`define ADCCFG_A_RO_FIRST 10'h15A

// ----------------------------------------
// reset values
// ----------------------------------------
`define ADCCFG_R_PWR 8'h24
`define ADCCFG_R_DIVIND 8'h0F
`define ADCCFG_R_RATE 8'h00
`define ADCCFG_R_RDTIME 8'h9F
`define ADCCFG_R_RAND 8'h62
`define ADCCFG_R_CALDLY 8'h80
`define ADCCFG_R_DLL 8'h0A
`define ADCCFG_R_CLKSRC 8'h45
`define ADCCFG_R_PLLREF 8'h00
`define ADCCFG_R_PLLOUT 8'h48
`define ADCCFG_R_PRELO 8'h78
`define ADCCFG_R_PREHI 8'h40
`define ADCCFG_R_CPUMP 8'h12
`define ADCCFG_R_PLLEN1 8'h41
`define ADCCFG_R_LRES 8'h2F
`define ADCCFG_R_LCAP 8'h27
`define ADCCFG_R_PLLEN2 8'hF1
`define ADCCFG_R_FMT 8'h10
`define ADCCFG_R_DRIVE 8'h01
`define ADCCFG_R_PHASE 8'h03
`define ADCCFG_R_POL 8'h00
`define ADCCFG_R_OFSLO 8'h00

// ----------------------------------------
// header fields and timing
// ----------------------------------------
`define ADCCFG_HDR_RW 15
`define ADCCFG_HDR_LEN_HI 14
`define ADCCFG_HDR_LEN_LO 13
`define ADCCFG_HDR_DEV_HI 12
`define ADCCFG_HDR_DEV_LO 10
`define ADCCFG_HDR_BITS 16
`define ADCCFG_POR_CYCLES 1048576

`endif

// *** logic/adccfg_bank.v ***
// Purpose: configuration register bank behind a three-wire serial port
// Assumes: serial clock well below clk/4; pins sampled by three flops
// Notes: read data leaves on falling serial edge, write data taken on rising
`timescale 1ns/1ps
`default_nettype none
`include "adccfg_map.vh"

module adccfg_bank #(
    parameter POR_CYCLES = `ADCCFG_POR_CYCLES,
    parameter [1:0] DEV_ADDR_PINS = 2'h0,
    parameter [7:0] RO_VALUE = 8'h00
) (
    // clock and resets
    input wire clk,
    input wire srst,
    input wire reset_pin,
    // serial pins
    input wire cs_n,
    input wire sclk,
    input wire sdio_i,
    output reg sdio_o,
    output reg sdio_oe,
    // decoded controls
    output reg init_done,
    output reg shutdown_mode,
    output reg lsb_first,
    output reg soft_reset_req,
    output reg standby_mode,
    output reg divider_independence_enable,
    output reg [3:0] output_word_rate,
    output reg [3:0] output_strobe_rate,
    output reg readback_edge_select,
    output reg pll_out_enable,
    output reg pll_bias_enable,
    output reg data_format,
    output reg [1:0] output_mode,
    output reg [2:0] pattern_generator_select,
    output reg phase_delay_enable,
    output reg [2:0] decimated_strobe_delay,
    output reg [5:0] lane_polarity_invert,
    output reg [7:0] offset_correction_low
);

    localparam NREG = 24;
    localparam [20:0] POR_LAST = POR_CYCLES - 1;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function [4:0] reg_index;
        input [9:0] a;
        begin
            case (a)
                `ADCCFG_A_PWR: reg_index = 5'h00;
                `ADCCFG_A_DIVIND: reg_index = 5'h01;
                `ADCCFG_A_RATE: reg_index = 5'h02;
                `ADCCFG_A_RDTIME: reg_index = 5'h03;
                `ADCCFG_A_RAND: reg_index = 5'h04;
                `ADCCFG_A_CALDLY: reg_index = 5'h05;
                `ADCCFG_A_DLL: reg_index = 5'h06;
                `ADCCFG_A_CLKSRC: reg_index = 5'h07;
                `ADCCFG_A_PLLREF: reg_index = 5'h08;
                `ADCCFG_A_PLLOUT: reg_index = 5'h09;
                `ADCCFG_A_PRELO: reg_index = 5'h0A;
                `ADCCFG_A_PREHI: reg_index = 5'h0B;
                `ADCCFG_A_CPUMP: reg_index = 5'h0C;
                `ADCCFG_A_PLLEN1: reg_index = 5'h0D;
                `ADCCFG_A_LRES: reg_index = 5'h0E;
                `ADCCFG_A_LCAP3: reg_index = 5'h0F;
                `ADCCFG_A_LCAP1: reg_index = 5'h10;
                `ADCCFG_A_LCAP2: reg_index = 5'h11;
                `ADCCFG_A_PLLEN2: reg_index = 5'h12;
                `ADCCFG_A_FMT: reg_index = 5'h13;
                `ADCCFG_A_DRIVE: reg_index = 5'h14;
                `ADCCFG_A_PHASE: reg_index = 5'h15;
                `ADCCFG_A_POL: reg_index = 5'h16;
                `ADCCFG_A_OFSLO: reg_index = 5'h17;
                default: reg_index = 5'h1F;
            endcase
        end
    endfunction

    function [7:0] reg_default;
        input [4:0] i;
        begin
            case (i)
                5'h00: reg_default = `ADCCFG_R_PWR;
                5'h01: reg_default = `ADCCFG_R_DIVIND;
                5'h02: reg_default = `ADCCFG_R_RATE;
                5'h03: reg_default = `ADCCFG_R_RDTIME;
                5'h04: reg_default = `ADCCFG_R_RAND;
                5'h05: reg_default = `ADCCFG_R_CALDLY;
                5'h06: reg_default = `ADCCFG_R_DLL;
                5'h07: reg_default = `ADCCFG_R_CLKSRC;
                5'h08: reg_default = `ADCCFG_R_PLLREF;
                5'h09: reg_default = `ADCCFG_R_PLLOUT;
                5'h0A: reg_default = `ADCCFG_R_PRELO;
                5'h0B: reg_default = `ADCCFG_R_PREHI;
                5'h0C: reg_default = `ADCCFG_R_CPUMP;
                5'h0D: reg_default = `ADCCFG_R_PLLEN1;
                5'h0E: reg_default = `ADCCFG_R_LRES;
                5'h0F: reg_default = `ADCCFG_R_LCAP;
                5'h10: reg_default = `ADCCFG_R_LCAP;
                5'h11: reg_default = `ADCCFG_R_LCAP;
                5'h12: reg_default = `ADCCFG_R_PLLEN2;
                5'h13: reg_default = `ADCCFG_R_FMT;
                5'h14: reg_default = `ADCCFG_R_DRIVE;
                5'h15: reg_default = `ADCCFG_R_PHASE;
                5'h16: reg_default = `ADCCFG_R_POL;
                5'h17: reg_default = `ADCCFG_R_OFSLO;
                default: reg_default = 8'h00;
            endcase
        end
    endfunction

    // bit reversal of one byte, shared by header and data paths
    function [7:0] rev8;
        input [7:0] b;
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1)
                rev8[k] = b[7 - k];
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // three stages; second and third must agree before a change counts
    reg [2:0] cs_sync_reg, sclk_sync_reg, sdi_sync_reg, rst_sync_reg;
    reg cs_n_reg, sclk_reg, sdi_reg, rst_pin_reg;

    always @(posedge clk) begin
        if (srst) begin
            cs_sync_reg <= 3'h7;
            sclk_sync_reg <= 3'h0;
            sdi_sync_reg <= 3'h0;
            rst_sync_reg <= 3'h0;
            cs_n_reg <= 1'b1;
            sclk_reg <= 1'b0;
            sdi_reg <= 1'b0;
            rst_pin_reg <= 1'b0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
            sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
            sdi_sync_reg <= {sdi_sync_reg[1:0], sdio_i};
            rst_sync_reg <= {rst_sync_reg[1:0], reset_pin};
            if (cs_sync_reg[1] == cs_sync_reg[2])
                cs_n_reg <= cs_sync_reg[2];
            if (sclk_sync_reg[1] == sclk_sync_reg[2])
                sclk_reg <= sclk_sync_reg[2];
            if (sdi_sync_reg[1] == sdi_sync_reg[2])
                sdi_reg <= sdi_sync_reg[2];
            if (rst_sync_reg[1] == rst_sync_reg[2])
                rst_pin_reg <= rst_sync_reg[2];
        end
    end

    wire sclk_filt = (sclk_sync_reg[1] == sclk_sync_reg[2]) ? sclk_sync_reg[2] : sclk_reg;
    wire sclk_rise = sclk_filt & ~sclk_reg;
    wire sclk_fall = ~sclk_filt & sclk_reg;

    // ----------------------------------------
    // power-on delay
    // ----------------------------------------
    reg [20:0] por_cnt_reg;
    reg por_done_reg;
    wire load_defaults = (~por_done_reg && por_cnt_reg == POR_LAST) || rst_pin_reg;

    always @(posedge clk) begin
        if (srst) begin
            por_cnt_reg <= 21'h000000;
            por_done_reg <= 1'b0;
        end else if (~por_done_reg) begin
            por_cnt_reg <= por_cnt_reg + 21'h000001;
            if (por_cnt_reg == POR_LAST)
                por_done_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // serial frame engine
    // ----------------------------------------
    localparam [1:0] ST_HDR = 2'h0;
    localparam [1:0] ST_WR = 2'h1;
    localparam [1:0] ST_RD = 2'h2;
    localparam [1:0] ST_IDLE = 2'h3;

    reg [1:0] state_reg;
    reg [15:0] hdr_reg;
    reg [4:0] bitcnt_reg;
    reg [9:0] addr_reg;
    reg [1:0] bytes_left_reg;
    reg [7:0] shift_reg;
    reg [7:0] regs [0:NREG-1];

    wire [15:0] hdr_next = {hdr_reg[14:0], sdi_reg};
    // lsb-first reverses bit order within each byte of header and data
    wire [15:0] hdr_fix = lsb_first ? {rev8(hdr_next[15:8]), rev8(hdr_next[7:0])} : hdr_next;
    wire dev_match = hdr_fix[`ADCCFG_HDR_DEV_HI:`ADCCFG_HDR_DEV_LO] == {1'b0, DEV_ADDR_PINS};
    wire [7:0] rx_next = {shift_reg[6:0], sdi_reg};
    wire [7:0] wr_byte = lsb_first ? rev8(rx_next) : rx_next;
    wire [4:0] cur_idx = reg_index(addr_reg);
    wire addr_ro = addr_reg >= `ADCCFG_A_RO_FIRST && addr_reg <= `ADCCFG_A_LAST;

    reg [7:0] rd_byte;
    always @* begin
        if (addr_ro)
            rd_byte = RO_VALUE;
        else if (cur_idx < NREG)
            rd_byte = regs[cur_idx];
        else
            rd_byte = 8'h00;
    end

    wire [9:0] hdr_addr = hdr_fix[9:0];
    wire byte_end = bitcnt_reg == 5'h07 &&
        (state_reg == ST_WR ? sclk_rise : state_reg == ST_RD && sclk_fall);

    reg write_pulse;
    always @* begin
        write_pulse = 1'b0;
        if (state_reg == ST_WR && sclk_rise && bitcnt_reg == 5'h07 && ~cs_n_reg)
            write_pulse = 1'b1;
    end

    always @(posedge clk) begin
        if (srst || cs_n_reg) begin
            state_reg <= ST_HDR;
            hdr_reg <= 16'h0000;
            bitcnt_reg <= 5'h00;
            addr_reg <= 10'h000;
            bytes_left_reg <= 2'h0;
            shift_reg <= 8'h00;
            sdio_oe <= 1'b0;
            sdio_o <= 1'b0;
        end else begin
            case (state_reg)
                ST_HDR: begin
                    if (sclk_rise) begin
                        hdr_reg <= hdr_next;
                        bitcnt_reg <= bitcnt_reg + 5'h01;
                        if (bitcnt_reg == `ADCCFG_HDR_BITS - 1) begin
                            bitcnt_reg <= 5'h00;
                            addr_reg <= hdr_addr;
                            bytes_left_reg <= {hdr_fix[`ADCCFG_HDR_LEN_HI],
                                hdr_fix[`ADCCFG_HDR_LEN_LO]};
                            if (~dev_match)
                                state_reg <= ST_IDLE;
                            else if (hdr_fix[`ADCCFG_HDR_RW])
                                state_reg <= ST_RD;
                            else
                                state_reg <= ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (sclk_rise) begin
                        shift_reg <= rx_next;
                        bitcnt_reg <= bitcnt_reg + 5'h01;
                    end
                end
                ST_RD: begin
                    if (sclk_fall) begin
                        sdio_oe <= 1'b1;
                        if (bitcnt_reg == 5'h00)
                            shift_reg <= rd_byte;
                        sdio_o <= bitcnt_reg == 5'h00
                            ? (lsb_first ? rd_byte[0] : rd_byte[7])
                            : (lsb_first ? shift_reg[bitcnt_reg[2:0]]
                                : shift_reg[3'h7 - bitcnt_reg[2:0]]);
                        bitcnt_reg <= bitcnt_reg + 5'h01;
                    end
                end
                ST_IDLE: begin
                    // after a read keeps driving the last bit until cs rises; after a write or device mismatch sdio_oe stays low
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_HDR;
            endcase
            if (byte_end) begin
                bitcnt_reg <= 5'h00;
                if (addr_reg != `ADCCFG_A_LAST)
                    addr_reg <= addr_reg + 10'h001;
                if (bytes_left_reg == 2'h0)
                    state_reg <= ST_IDLE;
                else if (bytes_left_reg != 2'h3)
                    bytes_left_reg <= bytes_left_reg - 2'h1;
            end
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : gen_reg
            always @(posedge clk) begin
                if (srst)
                    regs[g] <= reg_default(g[4:0]);
                else if (load_defaults)
                    regs[g] <= reg_default(g[4:0]);
                else if (write_pulse && cur_idx == g && ~addr_ro)
                    regs[g] <= wr_byte;
            end
        end
    endgenerate

    // ----------------------------------------
    // decoded outputs
    // ----------------------------------------
    // mirrored bits of the control byte: either copy set asserts the function, except soft reset, asserted by either copy clear
    always @(posedge clk) begin
        if (srst) begin
            init_done <= 1'b0;
            shutdown_mode <= 1'b0;
            lsb_first <= 1'b0;
            soft_reset_req <= 1'b0;
            standby_mode <= 1'b0;
            divider_independence_enable <= 1'b0;
            output_word_rate <= 4'h0;
            output_strobe_rate <= 4'h0;
            readback_edge_select <= 1'b1;
            pll_out_enable <= 1'b0;
            pll_bias_enable <= 1'b0;
            data_format <= 1'b0;
            output_mode <= 2'h2;
            pattern_generator_select <= 3'h0;
            phase_delay_enable <= 1'b0;
            decimated_strobe_delay <= 3'h0;
            lane_polarity_invert <= 6'h00;
            offset_correction_low <= 8'h00;
        end else begin
            init_done <= por_done_reg;
            shutdown_mode <= regs[0][7] | regs[0][0];
            lsb_first <= regs[0][6] | regs[0][1];
            soft_reset_req <= ~regs[0][5] | ~regs[0][2];
            standby_mode <= regs[0][4] | regs[0][3];
            divider_independence_enable <= regs[1][7];
            output_word_rate <= regs[2][7:4];
            output_strobe_rate <= regs[2][3:0];
            readback_edge_select <= regs[3][7];
            pll_out_enable <= regs[18][3];
            pll_bias_enable <= regs[18][2];
            data_format <= regs[19][5];
            output_mode <= regs[19][4:3];
            pattern_generator_select <= regs[19][2:0];
            phase_delay_enable <= regs[21][7];
            decimated_strobe_delay <= regs[21][6:4];
            lane_polarity_invert <= regs[22][7:2];
            offset_correction_low <= regs[23];
        end
    end

endmodule
`default_nettype wire

// *** tb/adccfg_checker_properties.sv ***
// Purpose: port-level properties of the config register bank
// Assumes: sclk phases last at least five clk cycles
// Notes: reset checks allow for the pin synchroniser
`timescale 1ns/1ps
`default_nettype none
module adccfg_checker #(
    parameter POR_CYCLES = 16
) (
    // clock and resets
    input wire logic clk,
    input wire logic srst,
    input wire logic reset_pin,
    // serial pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdio_o,
    input wire logic sdio_oe,
    // decoded controls
    input wire logic init_done,
    input wire logic shutdown_mode,
    input wire logic lsb_first,
    input wire logic soft_reset_req,
    input wire logic standby_mode,
    input wire logic readback_edge_select,
    input wire logic [3:0] output_word_rate,
    input wire logic [1:0] output_mode,
    input wire logic [5:0] lane_polarity_invert,
    input wire logic [7:0] offset_correction_low
);
    int por_cnt_reg;
    int quiet_cnt_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ----
    // helper counters
    // ----
    // saturating, so long runs never wrap
    always @(posedge clk) begin
        por_cnt_reg <= srst ? 0 : por_cnt_reg + ((por_cnt_reg < POR_CYCLES + 8) ? 1 : 0);
        quiet_cnt_reg <= (srst || reset_pin || !cs_n) ? 0 :
            quiet_cnt_reg + ((quiet_cnt_reg < 16) ? 1 : 0);
    end
    // ----
    // properties
    // ----
    sequence s_srst_held;
        srst ##1 srst;
    endsequence
    sequence s_pin_held;
        reset_pin [*8];
    endsequence
    sequence s_sclk_high;
        sclk [*4];
    endsequence
    a_srst_fields: assert property (disable iff (reset_pin)
        s_srst_held |=> output_mode == 2'h2 && offset_correction_low == 8'h00 &&
        lane_polarity_invert == 6'h00 && output_word_rate == 4'h0 && readback_edge_select)
        else $error("fields not at defaults after reset");
    a_srst_power_bits: assert property (disable iff (reset_pin)
        s_srst_held |=> !shutdown_mode && !lsb_first && !soft_reset_req && !standby_mode &&
        !sdio_oe && !init_done)
        else $error("power byte decode wrong after reset");
    a_pin_defaults: assert property (
        s_pin_held |-> offset_correction_low == 8'h00 && output_mode == 2'h2 && !lsb_first &&
        readback_edge_select)
        else $error("reset pin did not restore defaults");
    a_init_early: assert property (por_cnt_reg < POR_CYCLES - 2 |-> !init_done)
        else $error("init done before the power-on count");
    a_init_late: assert property (por_cnt_reg > POR_CYCLES + 3 |-> init_done)
        else $error("init done missing after the power-on count");
    a_oe_in_frame: assert property (sdio_oe |-> !$past(cs_n, 6))
        else $error("data driven outside a frame");
    a_oe_release: assert property ($rose(cs_n) |-> ##[1:7] !sdio_oe)
        else $error("data line not released after frame");
    a_out_hold: assert property (s_sclk_high |-> $stable(sdio_o))
        else $error("read data moved while sclk high");
    a_regs_quiet: assert property (
        quiet_cnt_reg >= 12 && init_done && $past(init_done, 2) |->
        $stable({offset_correction_low, lane_polarity_invert, output_word_rate, lsb_first}))
        else $error("register changed without a serial command");
endmodule
bind adccfg_bank adccfg_checker #(.POR_CYCLES(POR_CYCLES)) u_adccfg_checker (.*);
`default_nettype wire

// *** tb/adccfg_host.sv ***
// Purpose: serial host model facing the config bank
// Assumes: each sclk phase lasts H clk cycles
// Notes: bytes pass through queue q in both directions
`timescale 1ns/1ps
`default_nettype none
module adccfg_host #(
    parameter int H = 8
) (
    // system
    input wire logic clk,
    // serial pins
    output logic cs_n,
    output logic sclk,
    output logic sdio_i,
    input wire logic sdio_o,
    input wire logic sdio_oe
);
    logic lsb;
    logic [7:0] q [$];
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdio_i = 1'b0;
        lsb = 1'b0;
    end
    // bit k of b leaves k-th; b is tx reversed per byte in msb-first mode
    task automatic shift(input logic [7:0] tx, input bit rd);
        logic [7:0] b;
        logic [7:0] v;
        for (int k = 0; k < 8; k++) b[k] = lsb ? tx[k] : tx[7 - k];
        for (int k = 0; k < 8; k++) begin
            @(negedge clk);
            sclk = 1'b0;
            // released line toggles so a stale level never reads back
            sdio_i = rd ? ~sdio_i : b[k];
            repeat (H) @(negedge clk);
            v[lsb ? k : 7 - k] = sdio_oe ? sdio_o : 1'bx;
            sclk = 1'b1;
            repeat (H - 1) @(negedge clk);
        end
        if (rd) q.push_back(v);
    endtask
    task automatic frame(input bit rd, input logic [1:0] len, input logic [2:0] dev,
                         input logic [9:0] a, input int n);
        @(negedge clk);
        cs_n = 1'b0;
        repeat (H) @(negedge clk);
        shift({rd, len, dev, a[9:8]}, 1'b0);
        shift(a[7:0], 1'b0);
        for (int j = 0; j < n; j++) shift(rd ? 8'h00 : q.pop_front(), rd);
        @(negedge clk);
        sclk = 1'b0;
        repeat (H) @(negedge clk);
        cs_n = 1'b1;
        sdio_i = ~sdio_i;
        repeat (2 * H) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: self-checking bench for the config register bank
// Assumes: host paces sclk at eight clk cycles per phase
// Notes: power-on count shortened to keep the run brief
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int POR = 16;
    localparam logic [7:0] ROV = 8'hA5; // arbitrary read-only content
    localparam logic [2:0] DEV = 3'h2;
    logic clk, srst, reset_pin, cs_n, sclk, sdio_i, sdio_o, sdio_oe, init_done;
    logic shutdown_mode, lsb_first, soft_reset_req, standby_mode, divider_independence_enable;
    logic readback_edge_select, pll_out_enable, pll_bias_enable, data_format, phase_delay_enable;
    logic [3:0] output_word_rate, output_strobe_rate;
    logic [1:0] output_mode;
    logic [2:0] pattern_generator_select, decimated_strobe_delay;
    logic [5:0] lane_polarity_invert;
    logic [7:0] offset_correction_low, d;
    logic [7:0] mdl [int];
    int miscompares, n_checks;
    logic [9:0] am [24] = '{10'h000, 10'h001, 10'h002, 10'h004, 10'h007, 10'h01E, 10'h052,
        10'h053, 10'h054, 10'h055, 10'h056, 10'h057, 10'h058, 10'h059, 10'h05A, 10'h05B,
        10'h05C, 10'h05D, 10'h05F, 10'h062, 10'h063, 10'h064, 10'h065, 10'h066};
    logic [7:0] dv [24] = '{8'h24, 8'h0F, 8'h00, 8'h9F, 8'h62, 8'h80, 8'h0A, 8'h45, 8'h00,
        8'h48, 8'h78, 8'h40, 8'h12, 8'h41, 8'h2F, 8'h27, 8'h27, 8'h27, 8'hF1, 8'h10, 8'h01,
        8'h03, 8'h00, 8'h00};
    // factory bits kept fixed: random bits only under the mask
    logic [9:0] fa [10] = '{10'h001, 10'h002, 10'h004, 10'h05F, 10'h062, 10'h064, 10'h065,
        10'h066, 10'h01E, 10'h054};
    logic [7:0] fm [10] = '{8'h80, 8'hFF, 8'h80, 8'h0C, 8'h3F, 8'hF0, 8'hFC, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0] ff [10] = '{8'h0F, 8'h00, 8'h1F, 8'hF1, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] pv [5] = '{8'hA4, 8'h25, 8'h2C, 8'h04, 8'h66};
    adccfg_bank #(.POR_CYCLES(POR), .DEV_ADDR_PINS(2'h2), .RO_VALUE(ROV)) u_adccfg_bank (.*);
    adccfg_host #(.H(8)) u_adccfg_host (.*);
    // ----
    // model and checking tasks
    // ----
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        n_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask
    task automatic load_defaults();
        foreach (am[i]) mdl[am[i]] = dv[i];
    endtask
    function automatic logic [7:0] exp_rd(input logic [9:0] a);
        if (a >= 10'h15A && a <= 10'h15D) return ROV;
        return mdl.exists(a) ? mdl[a] : 8'h00;
    endfunction
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        u_adccfg_host.q = '{v};
        u_adccfg_host.frame(1'b0, 2'h0, DEV, a, 1);
        if (mdl.exists(a)) mdl[a] = v;
    endtask
    task automatic rd(input logic [9:0] a);
        u_adccfg_host.frame(1'b1, 2'h0, DEV, a, 1);
        check(u_adccfg_host.q.pop_front(), exp_rd(a));
    endtask
    task automatic chk_out();
        logic [7:0] m;
        m = mdl[0];
        check({shutdown_mode, lsb_first, soft_reset_req, standby_mode,
            divider_independence_enable, output_word_rate, output_strobe_rate,
            readback_edge_select, pll_out_enable, pll_bias_enable, data_format, output_mode,
            pattern_generator_select, phase_delay_enable, decimated_strobe_delay,
            lane_polarity_invert, offset_correction_low}, {m[7] | m[0], m[6] | m[1],
            ~m[5] | ~m[2], m[4] | m[3], mdl[1][7], mdl[2], mdl[4][7], mdl[10'h05F][3:2],
            mdl[10'h062][5:0], mdl[10'h064][7:4], mdl[10'h065][7:2], mdl[10'h066]});
    endtask
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ----
    // clock, watchdog, tests
    // ----
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (80000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
    initial begin
        srst = 1'b1;
        reset_pin = 1'b0;
        miscompares = 0;
        n_checks = 0;
        void'($urandom(32'hC215));
        load_defaults();
        repeat (16) @(negedge clk);
        srst = 1'b0;
        check(init_done, 1'b0);
        repeat (POR + 4) @(negedge clk);
        check(init_done, 1'b1);
        foreach (am[i]) rd(am[i]);
        chk_out();
        $display("test defaults done");
        repeat (2) foreach (fa[i]) begin
            d = (8'($urandom) & fm[i]) | ff[i];
            wr(fa[i], d);
            rd(fa[i]);
        end
        chk_out();
        $display("test random writes done");
        u_adccfg_host.q = '{(8'($urandom) & 8'hF0) | 8'h03, 8'($urandom) & 8'hFC, 8'($urandom)};
        foreach (u_adccfg_host.q[i]) mdl[10'h064 + i] = u_adccfg_host.q[i];
        u_adccfg_host.frame(1'b0, 2'h2, DEV, 10'h064, 3);
        u_adccfg_host.frame(1'b1, 2'h2, DEV, 10'h064, 3);
        for (int i = 0; i < 3; i++) check(u_adccfg_host.q.pop_front(), mdl[10'h064 + i]);
        u_adccfg_host.frame(1'b1, 2'h3, DEV, 10'h15B, 4);
        repeat (4) check(u_adccfg_host.q.pop_front(), ROV);
        $display("test bursts done");
        wr(10'h15A, 8'h3C);
        rd(10'h15A);
        wr(10'h003, 8'hFF);
        rd(10'h003);
        u_adccfg_host.q = '{8'h5A};
        u_adccfg_host.frame(1'b0, 2'h0, 3'h0, 10'h066, 1);
        rd(10'h066);
        $display("test refusals done");
        foreach (pv[i]) begin
            wr(10'h000, pv[i]);
            chk_out();
        end
        u_adccfg_host.lsb = 1'b1;
        rd(10'h000);
        wr(10'h066, 8'($urandom));
        rd(10'h066);
        wr(10'h000, 8'h24);
        u_adccfg_host.lsb = 1'b0;
        rd(10'h000);
        $display("test power byte done");
        reset_pin = 1'b1;
        repeat (10) @(negedge clk);
        reset_pin = 1'b0;
        repeat (8) @(negedge clk);
        load_defaults();
        foreach (am[i]) rd(am[i]);
        $display("test reset pin done");
        wr(10'h065, 8'hFC);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        repeat (POR + 4) @(negedge clk);
        load_defaults();
        rd(10'h065);
        chk_out();
        $display("test second reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
